// >>> verilog/job_select_pkg.sv
// constants and carrier types for the digital-input job selector
package job_select_pkg;
    // ============================================================
    // sizing
    localparam int NUM_INPUTS = 8;
    localparam int IDX_W      = 3;
    localparam int BIN_BITS   = 5;
    localparam int JOB_W      = 5;
    localparam int CNT_W      = 32;
    // ============================================================
    // timing
    localparam int CLK_MHZ       = 200;
    localparam int GAP_MS        = 50;
    localparam int GAP_CYCLES    = GAP_MS * 1000 * CLK_MHZ;
    localparam int SETTLE_MS     = 10;
    localparam int SETTLE_CYCLES = SETTLE_MS * 1000 * CLK_MHZ;
    // ============================================================
    // reset values
    localparam logic [JOB_W-1:0] JOB_RESET = 5'h01;
    // ============================================================
    // selection modes
    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_TWO_JOB,
        MODE_BINARY,
        MODE_PULSE
    } sel_mode_t;

    // input assignment for each selection function
    typedef struct packed {
        sel_mode_t                      mode;
        logic [IDX_W-1:0]               two_job_idx;
        logic [IDX_W-1:0]               pulse_idx;
        logic [BIN_BITS-1:0][IDX_W-1:0] bit_idx;
        logic [BIN_BITS-1:0]            bit_used;
        logic                           confirm_en;
    } sel_cfg_t;

    // request to the job loader: strobe and job number
    typedef struct packed {
        logic             valid;
        logic [JOB_W-1:0] job;
    } job_req_t;
endpackage

// >>> verilog/job_select.sv
// job selection from digital inputs: level, binary pattern or pulse count
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - with the two-job function, input low selects job 1 and input high selects job 2.
// - in binary mode up to five assigned inputs form a job number from 1 to 31.
// - in binary mode a change of the input pattern starts the job change at once.
// - after a binary change the shown active job updates only at the next trigger.
// - pulse selection is accepted only while ready is high, and the controller waits for it.
// - pulses are counted until a gap of at least 50 ms, then the count selects the job.
// - ready drops 50 ms after the last pulse of a sequence.
// - ready stays low until the switch-over to the new job is finished.
// - with confirm enabled, confirm rises after the change and only then ready rises.
// - every selection function may be mapped to any digital input by configuration.
module job_select
    import job_select_pkg::*;
#(
    parameter int GAP_CNT = job_select_pkg::GAP_CYCLES
) (
    input  wire logic                                 sys_clk,
    input  wire logic                                 rst_n,
    input  wire logic                                 clk_en,
    input  wire logic [job_select_pkg::NUM_INPUTS-1:0] din,
    input  wire logic                                 trigger,
    input  wire job_select_pkg::sel_cfg_t              cfg,
    input  wire logic [31:0]                          job_stored,
    output job_select_pkg::job_req_t                  load_req,
    input  wire logic                                 load_done,
    output logic [job_select_pkg::JOB_W-1:0]          active_job,
    output logic [job_select_pkg::JOB_W-1:0]          shown_job,
    output logic                                      ready,
    output logic                                      confirm,
    input  wire logic                                 confirm_ack,
    output logic                                      busy
);
    import job_select_pkg::*;

    // idle, waiting for the loader, waiting for the confirm acknowledge
    typedef enum {
        ST_IDLE,
        ST_LOAD,
        ST_CONFIRM
    } st_t;

    // ============================================================
    // input mapping
    // every selection function reads whichever input its index names
    function automatic logic pick(input logic [NUM_INPUTS-1:0] v, input logic [IDX_W-1:0] i);
        pick = v[i];
    endfunction

    function automatic logic [JOB_W-1:0] bin_value(input logic [NUM_INPUTS-1:0] v,
                                                   input sel_cfg_t c);
        logic [JOB_W-1:0] r;
        r = '0;
        for (int k = 0; k < BIN_BITS; k++) begin
            r[k] = c.bit_used[k] & pick(v, c.bit_idx[k]);
        end
        bin_value = r;
    endfunction

    logic [JOB_W-1:0] pattern;
    logic             two_lvl;
    logic             pulse_in;

    always_comb begin
        pattern  = bin_value(din, cfg);
        two_lvl  = pick(din, cfg.two_job_idx);
        pulse_in = pick(din, cfg.pulse_idx);
    end

    // ============================================================
    // state
    st_t              st_r;
    logic [JOB_W-1:0] active_r;
    logic [JOB_W-1:0] shown_r;
    logic [JOB_W-1:0] pend_r;
    logic [JOB_W-1:0] last_pat_r;
    logic             pulse_d_r;
    logic [JOB_W-1:0] pcnt_r;
    logic [CNT_W-1:0] gap_r;
    logic             counting_r;
    logic             ready_r;
    logic             confirm_r;
    logic             req_r;

    logic             pulse_rise;
    logic             gap_hit;
    logic             start_bin;
    logic             start_two;
    logic             start_pulse;
    logic             valid_pat;
    logic [JOB_W-1:0] two_job;
    // at most one cause starts a change per cycle, binary pattern first
    logic             start_any;
    logic [JOB_W-1:0] start_job;
    logic             load_fin;
    logic             conf_fin;

    // no debounce: the controller must settle the pattern, an in-between value is acted on
    always_comb begin
        pulse_rise  = pulse_in & ~pulse_d_r;
        gap_hit     = counting_r && (gap_r >= CNT_W'(GAP_CNT - 1));
        valid_pat   = (pattern != '0) && job_stored[pattern];
        start_bin   = (st_r == ST_IDLE) && (cfg.mode == MODE_BINARY)
                      && (pattern != last_pat_r) && valid_pat && (pattern != active_r);
        two_job     = two_lvl ? JOB_W'(2) : JOB_W'(1);
        start_two   = (st_r == ST_IDLE) && (cfg.mode == MODE_TWO_JOB)
                      && (two_job != active_r);
        start_pulse = (st_r == ST_IDLE) && (cfg.mode == MODE_PULSE) && gap_hit
                      && (pcnt_r != '0);
    end

    // ============================================================
    // pulse edge detection; the delayed copy resets low, the idle level of the pulse input,
    // so no false edge follows reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pulse_d_r <= 1'b0;
        end else if (clk_en) begin
            pulse_d_r <= pulse_in;
        end
    end

    // pulse counting and gap timing
    // rises seen while a change runs are not counted; a count past 31 wraps, and a wrap to 0 or to a job not stored is dropped
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pcnt_r     <= '0;
            gap_r      <= '0;
            counting_r <= 1'b0;
        end else if (clk_en) begin
            if (cfg.mode != MODE_PULSE) begin
                pcnt_r     <= '0;
                counting_r <= 1'b0;
                gap_r      <= '0;
            end else if (pulse_rise && ready_r && st_r == ST_IDLE) begin
                pcnt_r     <= pcnt_r + JOB_W'(1);
                counting_r <= 1'b1;
                gap_r      <= '0;
            end else if (pulse_in) begin
                gap_r <= '0;
            end else if (gap_hit) begin
                counting_r <= 1'b0;
                pcnt_r     <= '0;
                gap_r      <= '0;
            end else if (counting_r) begin
                gap_r <= gap_r + CNT_W'(1);
            end
        end
    end

    // ============================================================
    // job change sequencing
    // one change at a time: a binary or two-job cause seen while busy waits until the block is idle again; pulse rises then are not counted
    always_comb begin
        start_any = 1'b0;
        start_job = pend_r;
        if (start_bin) begin
            start_any = 1'b1;
            start_job = pattern;
        end else if (start_two) begin
            start_any = 1'b1;
            start_job = two_job;
        end else if (start_pulse && job_stored[pcnt_r]) begin
            start_any = 1'b1;
            start_job = pcnt_r;
        end
        load_fin = (st_r == ST_LOAD) && load_done && !req_r;
        conf_fin = (st_r == ST_CONFIRM) && confirm_ack;
    end

    // sequencer: idle, loading, and the optional wait for the confirm acknowledge
    // the loader's answer is only taken from the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
        end else if (clk_en) begin
            case (st_r)
                ST_IDLE: begin
                    if (start_any) begin
                        st_r <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (load_fin) begin
                        if (cfg.confirm_en) begin
                            st_r <= ST_CONFIRM;
                        end else begin
                            st_r <= ST_IDLE;
                        end
                    end
                end
                ST_CONFIRM: begin
                    if (conf_fin) begin
                        st_r <= ST_IDLE;
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // request to the loader: a one-cycle strobe; the job word stands until the next request
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pend_r <= JOB_RESET;
            req_r  <= 1'b0;
        end else if (clk_en) begin
            req_r <= start_any;
            if (start_any) begin
                pend_r <= start_job;
            end
        end
    end

    // the new job counts as active only once the loader reports it finished
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            active_r <= JOB_RESET;
        end else if (clk_en) begin
            if (load_fin) begin
                active_r <= pend_r;
            end
        end
    end

    // ready falls with the request and rises only when the change is complete
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ready_r <= 1'b1;
        end else if (clk_en) begin
            if (start_any) begin
                ready_r <= 1'b0;
            end else if (load_fin && !cfg.confirm_en) begin
                ready_r <= 1'b1;
            end else if (conf_fin) begin
                ready_r <= 1'b1;
            end
        end
    end

    // confirm stands from the end of the load until the controller acknowledges it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            confirm_r <= 1'b0;
        end else if (clk_en) begin
            if (load_fin && cfg.confirm_en) begin
                confirm_r <= 1'b1;
            end else if (conf_fin) begin
                confirm_r <= 1'b0;
            end
        end
    end

    // ============================================================
    // pattern history and active job display
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            last_pat_r <= '0;
        end else if (clk_en) begin
            // history follows the inputs only while idle, so a pattern changed during a load
            // still counts as a change once the block is idle again
            if (st_r == ST_IDLE) begin
                last_pat_r <= pattern;
            end
        end
    end

    // the shown job follows the active one only on a trigger taken while idle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            shown_r <= JOB_RESET;
        end else if (clk_en) begin
            if (trigger && st_r == ST_IDLE) begin
                shown_r <= active_r;
            end
        end
    end

    // ============================================================
    // outputs
    always_comb begin
        load_req.valid = req_r;
        load_req.job   = pend_r;
        active_job     = active_r;
        shown_job      = shown_r;
        ready          = ready_r;
        confirm        = confirm_r;
        // busy comes straight from the state, so it rises together with the request
        busy           = (st_r != ST_IDLE);
    end
endmodule

`default_nettype wire

// >>> bench/job_select_assertions.sv
// port assertions for the job selector
`timescale 1ns/1ps
`default_nettype none
module job_select_chk
    import job_select_pkg::*;
#(
    parameter int GAP_CNT = 20
) (
    input wire logic                     sys_clk,
    input wire logic                     rst_n,
    input wire logic                     clk_en,
    input wire logic [7:0]               din,
    input wire logic                     trigger,
    input wire job_select_pkg::sel_cfg_t cfg,
    input wire logic [31:0]              job_stored,
    input wire job_select_pkg::job_req_t load_req,
    input wire logic                     load_done,
    input wire logic [4:0]               active_job,
    input wire logic [4:0]               shown_job,
    input wire logic                     ready,
    input wire logic                     confirm,
    input wire logic                     busy
);
    // ==========
    // helpers: binary pattern and low time of the pulse input
    logic [4:0]  pat;
    logic [31:0] low_cnt;
    always_comb begin
        for (int k = 0; k < BIN_BITS; k++) begin
            pat[k] = cfg.bit_used[k] & din[cfg.bit_idx[k]];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n || din[cfg.pulse_idx]) begin
            low_cnt <= 32'h0;
        end else if (clk_en) begin
            low_cnt <= low_cnt + 32'h1;
        end
    end
    // ==========
    // properties
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n || !clk_en);
    a_req_one_cycle: assert property (load_req.valid |=> !load_req.valid)
        else $error("request longer than one cycle");
    a_req_not_ready: assert property (load_req.valid |-> !ready && busy)
        else $error("ready high during change");
    a_active_after_done: assert property ($changed(active_job) |-> $past(load_done))
        else $error("active job changed before loader done");
    a_shown_on_trig: assert property ($changed(shown_job) |->
        $past(trigger) && shown_job == $past(active_job))
        else $error("shown job changed without trigger");
    a_two_job_level: assert property (cfg.mode == MODE_TWO_JOB && ready && !busy
        && active_job != 5'h01 + din[cfg.two_job_idx] |=> load_req.valid
        && load_req.job == 5'h01 + $past(din[cfg.two_job_idx]))
        else $error("two-job level not followed");
    a_bin_change: assert property (cfg.mode == MODE_BINARY && ready && $past(ready)
        && pat != $past(pat) && pat != 5'h00 && job_stored[pat] && pat != active_job
        |=> load_req.valid && load_req.job == $past(pat))
        else $error("binary change not started");
    a_bin_refuse: assert property (cfg.mode == MODE_BINARY && ready
        && (pat == 5'h00 || !job_stored[pat]) |=> !load_req.valid)
        else $error("zero or missing job accepted");
    a_pulse_gap: assert property (load_req.valid && cfg.mode == MODE_PULSE
        |-> low_cnt >= GAP_CNT && low_cnt <= GAP_CNT + 3)
        else $error("pulse change not at gap end");
    a_confirm_first: assert property (cfg.confirm_en && $rose(ready) |-> $past(confirm))
        else $error("ready rose before confirm");
endmodule
bind job_select job_select_chk #(.GAP_CNT(GAP_CNT)) u_chk (.*);
`default_nettype wire

// >>> bench/plc_pulser.sv
// controller model sending job selection pulses
`timescale 1ns/1ps
`default_nettype none
module plc_pulser #(
    parameter int HI = 4
) (
    input  wire logic       sys_clk,
    input  wire logic       ready,
    input  wire logic [4:0] n,
    input  wire logic       go,
    output logic            pin
);
    // ==========
    // pulse train, started only once ready is high
    initial begin
        pin = 1'b0;
        forever begin
            @(posedge go);
            wait (ready === 1'b1);
            @(posedge sys_clk);
            repeat (n) begin
                #1 pin = 1'b1;
                repeat (HI) @(posedge sys_clk);
                #1 pin = 1'b0;
                repeat (HI) @(posedge sys_clk);
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/job_select_tb_top.sv
// self-checking bench for the job selector
`timescale 1ns/1ps
`default_nettype none
module job_select_tb_top;
    import job_select_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  din_r = 8'h00;
    logic        trigger = 1'b0;
    logic        clk_en = 1'b1;
    sel_cfg_t    cfg = '0;
    logic [31:0] job_stored = 32'hFFFF_FFBF;
    job_req_t    load_req;
    logic [2:0]  dly = 3'h0;
    logic [4:0]  active_job, shown_job, n_p = 5'h00;
    logic        ready, confirm, busy, pin, confirm_ack = 1'b0, go = 1'b0;
    wire logic [7:0] din = din_r | {1'b0, pin, 6'h00};
    int          n_errors = 0;
    int          checked = 0;
    // ==========
    // clock, loader answer, instances
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) dly <= {dly[1:0], load_req.valid};
    job_select #(.GAP_CNT(20)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .din(din), .trigger(trigger), .cfg(cfg), .job_stored(job_stored),
        .load_req(load_req), .load_done(dly[2]), .active_job(active_job),
        .shown_job(shown_job), .ready(ready), .confirm(confirm),
        .confirm_ack(confirm_ack), .busy(busy));
    plc_pulser #(.HI(4)) u_plc (.sys_clk(sys_clk), .ready(ready), .n(n_p), .go(go), .pin(pin));
    // ==========
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic settle();
        int i;
        step(4);
        for (i = 0; i < 400 && !(ready === 1'b1 && busy === 1'b0); i++) step(1);
        if (i >= 400) check(32'h0, 32'h1);
    endtask
    task automatic set_pat(input logic [4:0] v);
        logic [7:0] pat_w;
        pat_w = 8'h00;
        for (int k = 0; k < 5; k++) pat_w[7-k] = v[k];
        din_r = pat_w;
        settle();
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        finish_test();
    end
    // ==========
    // tests
    initial begin
        int i;
        step(2);
        rst_n = 1'b1;
        check({ready, confirm, busy, load_req.valid, active_job, shown_job}, 14'h2021);
        clk_en = 1'b0;
        cfg.two_job_idx = 3'h2;
        cfg.mode = MODE_TWO_JOB;
        din_r = 8'h04;
        step(3);
        check({ready, busy, load_req.valid, active_job}, 8'h81);
        clk_en = 1'b1;
        settle();
        check(active_job, 5'h02);
        din_r = 8'h00;
        settle();
        check(active_job, 5'h01);
        for (int k = 0; k < 5; k++) cfg.bit_idx[k] = 3'(7 - k);
        cfg.bit_used = 5'h1F;
        cfg.mode = MODE_BINARY;
        set_pat(5'h13);
        check(active_job, 5'h13);
        check(shown_job, 5'h01);
        trigger = 1'b1;
        step(1);
        trigger = 1'b0;
        step(1);
        check(shown_job, 5'h13);
        set_pat(5'h06);
        check(active_job, 5'h13);
        set_pat(5'h1F);
        check(active_job, 5'h1F);
        set_pat(5'h00);
        check(active_job, 5'h1F);
        cfg.pulse_idx = 3'h6;
        cfg.confirm_en = 1'b1;
        cfg.mode = MODE_PULSE;
        n_p = 5'h03;
        go = 1'b1;
        step(1);
        go = 1'b0;
        for (i = 0; i < 400 && confirm !== 1'b1; i++) step(1);
        check({ready, confirm, active_job}, 7'h23);
        confirm_ack = 1'b1;
        step(1);
        confirm_ack = 1'b0;
        step(2);
        check({ready, confirm}, 2'h2);
        finish_test();
    end
endmodule
`default_nettype wire
